// >>> design/timer1_cmp_pkg.sv
// Constants and types for the timer1 compare output block, channels A and B
// Function
// - Control register at 0x30, documented reset zero
// - Nonzero A mode overrides A pin
// - Nonzero B mode overrides B pin outside six-output; in six-output, nonzero A mode does
// - A complement only in PWM, mode 01, or any nonzero A mode in six-output
// - B complement only in PWM, mode 01, or any nonzero A mode in six-output
// - A mode uses enable and the high bit only
// - B mode uses enable, low bit
// - Non-PWM: toggle, clear or set on match
// - Fast PWM 01/10: clear match, set bottom
// - Fast PWM 11: set match, clear bottom
// - Dual slope 01/10: clear up, set down
// - Dual slope 11: set up, clear down
// - Six-output: waveform A drives all pins
// - Six-output single slope follows fast rules
// - Six-output dual slope follows dual rules
// - Force applies action now, non-PWM only, reads zero
// - PWM enable selects PWM per channel
`default_nettype none

package timer1_cmp_pkg;

  // ==========================================================
  // Bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_TOP = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h44;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Field positions
  localparam int CTRL_OM_A_LSB = 6;
  localparam int CTRL_OM_B_LSB = 4;
  localparam int CTRL_FORCE_A = 3;
  localparam int CTRL_FORCE_B = 2;
  localparam int CTRL_PWM_A = 1;
  localparam int CTRL_PWM_B = 0;
  localparam logic [7:0] CTRL_STORE_MASK = 8'hF3;
  localparam int MODE_WGM_LO = 0;
  localparam int MODE_WGM_HI = 1;
  localparam int MODE_RUN = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CMP_RESET = 10'h000;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [9:0] TOP_RESET = 10'h3FF;
  localparam logic [9:0] COUNT_BOTTOM = 10'h000;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    OUTMODE_OFF = 2'b00,
    OUTMODE_TOGGLE = 2'b01,
    OUTMODE_CLEAR = 2'b10,
    OUTMODE_SET = 2'b11
  } outmode_t;

endpackage : timer1_cmp_pkg

`default_nettype wire

// >>> design/compare_waveform_unit.sv
// One compare channel: match detection and waveform register
`timescale 1ns/10ps
`default_nettype none

module compare_waveform_unit
  import timer1_cmp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timer state
  input wire logic tick,
  input wire logic [9:0] count,
  input wire logic count_down,
  input wire logic [9:0] compare,
  // Configuration
  input wire logic pwm,
  input wire logic dual,
  input wire logic [1:0] outmode,
  input wire logic force_match,
  // Waveform
  output logic wave
);

  logic next_wave;

  // ==========================================================
  // Events
  // equality match
  wire match = tick && (count == compare);
  wire bottom = tick && (count == COUNT_BOTTOM);
  wire set_kind = (outmode == OUTMODE_SET);

  always_comb begin
    next_wave = wave;
    if (!pwm) begin
      // non-PWM actions, force acts as match
      if (match || force_match) begin
        unique case (outmode)
          OUTMODE_OFF: next_wave = wave;
          OUTMODE_TOGGLE: next_wave = ~wave;
          OUTMODE_CLEAR: next_wave = 1'b0;
          OUTMODE_SET: next_wave = 1'b1;
        endcase
      end
    end else if (dual) begin
      if (match) begin
        next_wave = set_kind ^ count_down;
      end
    end else begin
      if (match) begin
        next_wave = set_kind;
      end else if (bottom) begin
        next_wave = ~set_kind;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

endmodule : compare_waveform_unit

`default_nettype wire

// >>> design/timer1_compare_output_mode_ab.sv
// Timer1 compare output logic for channels A and B with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

module timer1_compare_output_mode_ab
  import timer1_cmp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel A pins
  output logic chan_a_pin,
  output logic chan_a_pin_inv,
  output logic chan_a_override,
  output logic chan_a_inv_override,
  // Channel B pins
  output logic chan_b_pin,
  output logic chan_b_pin_inv,
  output logic chan_b_override,
  output logic chan_b_inv_override
);

  // ==========================================================
  // Declarations
  logic [7:0] timer1_output_control_a;
  logic [9:0] chan_a_compare_value;
  logic [9:0] chan_b_compare_value;
  logic [2:0] mode_cfg;
  logic [9:0] count_top;
  logic [9:0] timer1_count;
  logic count_down;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_is_ctrl;
  logic [1:0] wave;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_CMP_A) ||
      (a == OFS_CMP_B) || (a == OFS_MODE) || (a == OFS_TOP) ||
      (a == OFS_STATUS);
  endfunction : is_mapped

  function automatic logic [9:0] merge10(input logic [9:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    merge10 = {strb[1] ? data[9:8] : old[9:8],
      strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge10

  // ==========================================================
  // Write channel
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_got & w_got & ~s_axi_bvalid;
  wire next_aw_got = wr_fire ? 1'b0 : (aw_got | aw_take);
  wire next_w_got = wr_fire ? 1'b0 : (w_got | w_take);
  wire next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire wr_lane0 = wr_fire & wr_strb[0];
  wire wr_ctrl = wr_lane0 && (wr_addr == OFS_CTRL);
  wire wr_cmp_a = wr_fire && (wr_addr == OFS_CMP_A);
  wire wr_cmp_b = wr_fire && (wr_addr == OFS_CMP_B);
  wire wr_mode = wr_lane0 && (wr_addr == OFS_MODE);
  wire wr_top = wr_fire && (wr_addr == OFS_TOP);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Payload latches carry no reset value
  always_ff @(posedge clk_sys) begin
    if (aw_take) begin
      wr_addr <= s_axi_awaddr;
    end
    if (w_take) begin
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer1_output_control_a <= CTRL_RESET;
      chan_a_compare_value <= CMP_RESET;
      chan_b_compare_value <= CMP_RESET;
      mode_cfg <= MODE_RESET;
      count_top <= TOP_RESET;
    end else begin
      if (wr_ctrl) begin
        timer1_output_control_a <= wr_data[7:0] & CTRL_STORE_MASK;
      end
      if (wr_cmp_a) begin
        chan_a_compare_value <= merge10(chan_a_compare_value, wr_data,
          wr_strb);
      end
      if (wr_cmp_b) begin
        chan_b_compare_value <= merge10(chan_b_compare_value, wr_data,
          wr_strb);
      end
      if (wr_mode) begin
        mode_cfg <= wr_data[2:0];
      end
      if (wr_top) begin
        count_top <= merge10(count_top, wr_data, wr_strb);
      end
    end
  end

  // ==========================================================
  // Read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] status_word = {19'h0, wave, count_down, timer1_count};
  wire [31:0] rd_word =
    (s_axi_araddr == OFS_CTRL) ? {24'h000000, timer1_output_control_a} :
    (s_axi_araddr == OFS_CMP_A) ? {22'h0, chan_a_compare_value} :
    (s_axi_araddr == OFS_CMP_B) ? {22'h0, chan_b_compare_value} :
    (s_axi_araddr == OFS_MODE) ? {29'h0, mode_cfg} :
    (s_axi_araddr == OFS_TOP) ? {22'h0, count_top} :
    (s_axi_araddr == OFS_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
      rd_is_ctrl <= 1'b0;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rd_is_ctrl <= (s_axi_araddr == OFS_CTRL);
      end
    end
  end

  // ==========================================================
  // Configuration view
  // A mode change written with a force bit takes effect for that force
  wire [7:0] ctrl_eff = wr_ctrl ? wr_data[7:0] : timer1_output_control_a;
  wire [1:0] om_a = timer1_output_control_a[CTRL_OM_A_LSB +: 2];
  wire [1:0] om_b = timer1_output_control_a[CTRL_OM_B_LSB +: 2];
  wire pwm_a = timer1_output_control_a[CTRL_PWM_A];
  wire pwm_b = timer1_output_control_a[CTRL_PWM_B];
  wire wave_gen_mode_lo = mode_cfg[MODE_WGM_LO];
  wire wave_gen_mode_hi = mode_cfg[MODE_WGM_HI];
  wire run = mode_cfg[MODE_RUN];
  // A reads enable and the high mode bit only
  wire six_output_pwm = pwm_a & wave_gen_mode_hi;
  wire [1:0] ch_pwm = {ctrl_eff[CTRL_PWM_B], ctrl_eff[CTRL_PWM_A]};
  wire [3:0] ch_om = {ctrl_eff[CTRL_OM_B_LSB +: 2],
    ctrl_eff[CTRL_OM_A_LSB +: 2]};
  wire [1:0] ch_force = {wr_ctrl & wr_data[CTRL_FORCE_B],
    wr_ctrl & wr_data[CTRL_FORCE_A]} & ~ch_pwm;
  wire [19:0] ch_cmp = {chan_b_compare_value, chan_a_compare_value};

  // ==========================================================
  // Counter
  wire at_top = (timer1_count >= count_top);
  wire at_bottom = (timer1_count == COUNT_BOTTOM);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer1_count <= COUNT_BOTTOM;
      count_down <= 1'b0;
    end else if (run) begin
      if (count_top == COUNT_BOTTOM) begin
        timer1_count <= COUNT_BOTTOM;
        count_down <= 1'b0;
      end else if (!wave_gen_mode_lo) begin
        timer1_count <= at_top ? COUNT_BOTTOM : timer1_count + 10'h001;
        count_down <= 1'b0;
      end else if (!count_down) begin
        timer1_count <= at_top ? timer1_count - 10'h001 :
          timer1_count + 10'h001;
        count_down <= at_top;
      end else begin
        timer1_count <= at_bottom ? timer1_count + 10'h001 :
          timer1_count - 10'h001;
        count_down <= ~at_bottom;
      end
    end
  end

  // ==========================================================
  // Channels
  // B slope from the low mode bit only
  for (genvar i = 0; i < 2; i++) begin : g_chan
    compare_waveform_unit u_unit (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(run),
      .count(timer1_count),
      .count_down(count_down),
      .compare(ch_cmp[i*10 +: 10]),
      .pwm(ch_pwm[i]),
      .dual(wave_gen_mode_lo),
      .outmode(ch_om[i*2 +: 2]),
      .force_match(ch_force[i]),
      .wave(wave[i])
    );
  end

  // ==========================================================
  // Pin selection
  wire a_on = (om_a != OUTMODE_OFF);
  // complement needs PWM and mode 01
  wire a_inv_ok = pwm_a && (om_a == OUTMODE_TOGGLE);
  wire b_inv_ok = pwm_b && (om_b == OUTMODE_TOGGLE);
  wire next_a_override = a_on;
  wire next_b_override = six_output_pwm ? a_on : (om_b != OUTMODE_OFF);
  wire next_a_inv_override = six_output_pwm ? a_on : a_inv_ok;
  wire next_b_inv_override = six_output_pwm ? a_on : b_inv_ok;
  wire next_b_pin = six_output_pwm ? wave[0] : wave[1];

  // Registered pins add one cycle after the waveform
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_a_pin <= 1'b0;
      chan_a_pin_inv <= 1'b1;
      chan_a_override <= 1'b0;
      chan_a_inv_override <= 1'b0;
      chan_b_pin <= 1'b0;
      chan_b_pin_inv <= 1'b1;
      chan_b_override <= 1'b0;
      chan_b_inv_override <= 1'b0;
    end else begin
      chan_a_pin <= wave[0];
      chan_a_pin_inv <= ~wave[0];
      chan_a_override <= next_a_override;
      chan_a_inv_override <= next_a_inv_override;
      chan_b_pin <= next_b_pin;
      chan_b_pin_inv <= ~next_b_pin;
      chan_b_override <= next_b_override;
      chan_b_inv_override <= next_b_inv_override;
    end
  end

  // ==========================================================
  // Checks
  wire match_a = run && (timer1_count == chan_a_compare_value);
  wire match_b = run && (timer1_count == chan_b_compare_value);

  a_ctrl_force_zero: assert property (
    s_axi_rvalid && rd_is_ctrl && (s_axi_rresp == RESP_OKAY) |->
      (s_axi_rdata[3:2] == 2'b00) && (s_axi_rdata[31:8] == 24'h000000))
    else $error("control read shows force bits or upper bits");

  a_a_pin_override: assert property (
    (om_a != OUTMODE_OFF) |=> chan_a_override)
    else $error("channel A mode set but pin not taken");

  a_b_pin_override: assert property (
    !six_output_pwm && (om_b != OUTMODE_OFF) |=> chan_b_override)
    else $error("channel B mode set but pin not taken");

  a_a_inv_connect: assert property (
    chan_a_inv_override && !$past(six_output_pwm) |->
      $past(pwm_a) && ($past(om_a) == OUTMODE_TOGGLE))
    else $error("channel A complement connected outside PWM 01");

  a_b_inv_connect: assert property (
    chan_b_inv_override && !$past(six_output_pwm) |->
      $past(pwm_b) && ($past(om_b) == OUTMODE_TOGGLE))
    else $error("channel B complement connected outside PWM 01");

  a_fast_bottom_set: assert property (
    pwm_a && !wave_gen_mode_lo && !wr_ctrl && (om_a == OUTMODE_CLEAR) &&
      run && at_bottom && !match_a |=> wave[0] ##1 chan_a_pin)
    else $error("fast PWM clear mode did not set at bottom");

  a_fast_match_set: assert property (
    pwm_a && !wave_gen_mode_lo && !wr_ctrl && (om_a == OUTMODE_SET) &&
      match_a |=> wave[0])
    else $error("fast PWM set mode did not set on match");

  a_dual_up_clear: assert property (
    pwm_a && wave_gen_mode_lo && !wr_ctrl && (om_a != OUTMODE_OFF) &&
      (om_a != OUTMODE_SET) && !count_down && match_a |=> !wave[0])
    else $error("dual slope did not clear on up match");

  a_dual_down_clear: assert property (
    pwm_b && wave_gen_mode_lo && !wr_ctrl && (om_b == OUTMODE_SET) &&
      count_down && match_b |=> !wave[1])
    else $error("channel B dual slope did not clear on down match");

  a_six_drive_all: assert property (
    six_output_pwm && (om_a != OUTMODE_OFF) |=>
      (chan_b_pin == $past(wave[0])) && (chan_b_pin_inv != chan_b_pin) &&
      chan_b_override && chan_b_inv_override)
    else $error("six-output mode did not route waveform A");

  sequence force_toggle_a;
    wr_ctrl && wr_data[CTRL_FORCE_A] && !wr_data[CTRL_PWM_A] &&
      (wr_data[CTRL_OM_A_LSB +: 2] == OUTMODE_TOGGLE) && !match_a;
  endsequence

  sequence pin_follows_a;
    ##1 (wave[0] != $past(wave[0])) ##1 (chan_a_pin == $past(wave[0]));
  endsequence

  a_force_toggle_a: assert property (
    force_toggle_a |-> pin_follows_a)
    else $error("force did not toggle channel A");

endmodule : timer1_compare_output_mode_ab

`default_nettype wire

// >>> bench/power_stage_model.sv
// Model of the port pads and power stage fed by the compare pins
`timescale 1ns/10ps
`default_nettype none

module power_stage_model (
  // Clock
  input wire logic clk_sys,
  // From the compare block
  input wire logic [3:0] pin,
  input wire logic [3:0] ovr,
  // Port side
  input wire logic [3:0] ddr,
  input wire logic [3:0] port_val,
  // Pads
  output logic [3:0] pad
);
  // ==========================================================
  // Pads
  // Undriven pad wanders so a stale level is never mistaken for drive
  logic [3:0] float_pat = 4'h5;

  always @(posedge clk_sys) begin
    float_pat <= ~float_pat;
  end

  assign pad = (ddr & ((ovr & pin) | (~ovr & port_val))) |
               (~ddr & float_pat);
endmodule : power_stage_model

`default_nettype wire

// >>> bench/tb_timer1_compare_output_mode_ab.sv
// Self-checking testbench for the timer1 compare output block
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end end

module tb_timer1_compare_output_mode_ab
  import timer1_cmp_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic chan_a_pin, chan_a_pin_inv, chan_a_override, chan_a_inv_override;
  logic chan_b_pin, chan_b_pin_inv, chan_b_override, chan_b_inv_override;
  logic [3:0] ddr = 4'hF;
  logic [3:0] port_val = 4'h0;
  wire logic [3:0] pins;
  wire logic [3:0] ovr;
  wire logic [3:0] pad;
  int n_fail = 0;
  int cmp_count = 0;

  assign pins = {chan_b_pin_inv, chan_b_pin, chan_a_pin_inv, chan_a_pin};
  assign ovr = {chan_b_inv_override, chan_b_override,
                chan_a_inv_override, chan_a_override};

  always #5 clk_sys = ~clk_sys;

  timer1_compare_output_mode_ab i_timer1_compare_output_mode_ab (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .chan_a_pin(chan_a_pin), .chan_a_pin_inv(chan_a_pin_inv),
    .chan_a_override(chan_a_override),
    .chan_a_inv_override(chan_a_inv_override),
    .chan_b_pin(chan_b_pin), .chan_b_pin_inv(chan_b_pin_inv),
    .chan_b_override(chan_b_override),
    .chan_b_inv_override(chan_b_inv_override)
  );

  power_stage_model i_power_stage_model (
    .clk_sys(clk_sys), .pin(pins), .ovr(ovr), .ddr(ddr),
    .port_val(port_val), .pad(pad)
  );

  // ==========================================================
  // Bus tasks
  task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data,
                        output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] addr, output logic [31:0] data,
                        output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [1:0] r;
    axi_wr(addr, data, r);
  endtask : wr

  task automatic count_high(input int idx, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (pad[idx] === 1'b1) hi++;
    end
  endtask : count_high

  // ==========================================================
  // Scenarios
  task automatic t_reset_map;
    logic [31:0] d;
    logic [1:0] r;
    `CHK("overrides at reset", 4'h0, ovr)
    axi_rd(OFS_CTRL, d, r);
    `CHK("control reset", 32'h0, d)
    `CHK("control resp", RESP_OKAY, r)
    axi_rd(8'h50, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    axi_wr(8'h50, 32'h0, r);
    `CHK("unmapped write resp", RESP_SLVERR, r)
    axi_wr(OFS_STATUS, 32'hFFFFFFFF, r);
    `CHK("status write resp", RESP_OKAY, r)
  endtask : t_reset_map

  task automatic t_force;
    logic [7:0] c [4] = '{8'h48, 8'h48, 8'hC8, 8'h88};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {24'h0, c[i]});
      repeat (3) @(posedge clk_sys);
      `CHK("force a pin", e[i], pad[0])
      `CHK("a override", 1'b1, chan_a_override)
      `CHK("a inv override", 1'b0, chan_a_inv_override)
    end
    axi_rd(OFS_CTRL, d, r);
    `CHK("force reads zero", 32'h80, d)
    wr(OFS_CTRL, 32'h14);
    repeat (3) @(posedge clk_sys);
    `CHK("force b pin", 1'b1, pad[2])
    `CHK("b override", 1'b1, chan_b_override)
    `CHK("a released", 1'b0, chan_a_override)
    axi_rd(OFS_STATUS, d, r);
    `CHK("status waveforms", 32'h1000, d)
  endtask : t_force

  // Compare 5, top 16: fast period 17, dual period 32
  task automatic t_pwm;
    logic [7:0] c [9] = '{8'h42, 8'hC2, 8'h82, 8'hC2,
                          8'h11, 8'h42, 8'hC2, 8'h31, 8'h82};
    logic [2:0] m [9] = '{3'h4, 3'h4, 3'h5, 3'h5, 3'h4, 3'h6, 3'h7,
                          3'h7, 3'h4};
    int idx [9] = '{0, 0, 0, 0, 2, 2, 2, 2, 0};
    int per [9] = '{17, 17, 32, 32, 17, 17, 32, 32, 17};
    int hi [9] = '{5, 12, 10, 22, 5, 5, 22, 22, 5};
    logic inv [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
                      1'b0};
    int h;
    wr(OFS_TOP, 32'h10);
    wr(OFS_CMP_A, 32'h5);
    wr(OFS_CMP_B, 32'h5);
    for (int i = 0; i < 9; i++) begin
      wr(OFS_CTRL, {24'h0, c[i]});
      wr(OFS_MODE, {29'h0, m[i]});
      repeat (70) @(posedge clk_sys);
      count_high(idx[i], 4 * per[i], h);
      `CHK("high cycles", 4 * hi[i], h)
      // Unconnected complement pad shows the port level, low here
      count_high(idx[i] + 1, 4 * per[i], h);
      `CHK("complement high", inv[i] ? 4 * (per[i] - hi[i]) : 0, h)
      `CHK("inv override", inv[i], ovr[idx[i] + 1])
      `CHK("true override", 1'b1, ovr[idx[i]])
    end
    wr(OFS_MODE, 32'h0);
  endtask : t_pwm

  // ==========================================================
  // Run control
  task automatic conclude;
    $display("mismatches %0d of %0d comparisons", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_map();
    t_force();
    t_pwm();
    conclude();
  end

  // Whole run is a few thousand cycles; this bound only catches a hang
  initial begin
    repeat (50000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
endmodule : tb_timer1_compare_output_mode_ab

`default_nettype wire
